// ---- core/flash_program_control.v ----
// Behaviour
// - Programming launches only after writes of 5 then A to the nibble.
// - Latch map bit routes data writes into the page buffer latches.
// - Busy flag set during programming, cleared by hardware only.
// - Flash control resets to all zeros.
// - Array is 256 pages of 128 bytes; one page per operation.
// - Each operation self-erases the loaded locations before writing.
// - Erase-and-program takes about 10 ms; busy lasts that long.
// - Flash reads are byte-wise with no wait state.
// - External access pin low disables internal program memory.
// - Security bit 7 low selects double speed, high standard mode.
// - Security bit 6 set boots at 0000h, clear at F400h.
// - Security bits 5-4 select oscillator range; 00 is illegal.
// - Three lock bits in security bits 2-0; bit 3 reserved.
// - Security byte takes parallel programming writes only while lock bits are 111, which reset (000) never gives; a security-space launch writes bits 7-4.
// - Mode field picks user, extra row, security; 11 launches nothing.
// - During programming flash is unfetchable and the CPU idles.
// - Lock levels 2, 3 and 4 block progressively more access.
`include "flash_program_control_consts.vh"
`default_nettype none

module flash_program_control
#(
  parameter PROG_CYCLES = `PROG_CYCLES
)
(
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // CPU special function register port.
  input  wire        i_sfr_wr,
  input  wire [7:0]  i_sfr_addr,
  input  wire [7:0]  i_sfr_wdata,
  output wire [7:0]  o_flash_control,
  // CPU data memory write port.
  input  wire        i_xdata_wr,
  input  wire [15:0] i_xdata_addr,
  input  wire [7:0]  i_xdata_wdata,
  output wire        o_xdata_to_latches,
  // CPU fetch status.
  output wire        o_flash_read_space_sel,
  output wire [1:0]  o_flash_space_select,
  output wire        o_fetch_wait,
  output wire        o_cpu_idle,
  // Pins and parallel programmer.
  input  wire        i_external_access_pin,
  input  wire        i_par_hsb_wr,
  input  wire [7:0]  i_par_hsb_wdata,
  // Flash array write port.
  output reg         o_array_erase,
  output reg         o_array_write,
  output reg  [1:0]  o_array_space,
  output reg  [7:0]  o_array_page,
  output reg  [6:0]  o_array_byte,
  output reg  [7:0]  o_array_data,
  // Decoded security byte.
  output wire [7:0]  o_hardware_security_byte,
  output wire        o_clock_ratio_select,
  output wire [15:0] o_boot_address,
  output wire [1:0]  o_osc_range_field,
  output wire        o_osc_range_illegal,
  output wire [2:0]  o_memory_lock_bits,
  output wire [2:0]  o_lock_level_m1,
  output wire        o_internal_code_enable,
  output wire        o_block_ext_movc,
  output wire        o_block_parallel_prog,
  output wire        o_block_parallel_verify,
  output wire        o_block_ext_exec
);

  // --------------------------------------------------------------------
  // States and timing.
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_SCAN  = 3'b010;
  localparam [2:0] ST_WAIT  = 3'b100;
  // The count is cut to the timer width on purpose; 24 bits hold 10 ms.
  localparam [31:0] PROG_LAST_W = PROG_CYCLES - 1;
  localparam [23:0] PROG_LAST   = PROG_LAST_W[23:0];

  reg  [2:0]  state_reg;
  reg  [3:0]  launch_code_nibble_reg;
  reg         latch_map_select_reg;
  reg  [1:0]  flash_space_select_reg;
  reg         program_busy_flag_reg;
  reg         unlock_armed_reg;
  reg  [7:0]  page_reg;
  reg  [7:0]  hsb_reg;
  reg  [23:0] time_reg;
  reg  [7:0]  scan_reg;
  reg         scan_valid_reg;
  reg  [6:0]  scan_byte_reg;
  reg  [1:0]  ea_sync_reg;

  wire       fc_wr = i_sfr_wr && (i_sfr_addr == `FLASH_CONTROL_ADDR);
  wire [3:0] wr_nib = i_sfr_wdata[`FC_LAUNCH_MSB:`FC_LAUNCH_LSB];
  wire [1:0] wr_space = i_sfr_wdata[`FC_SPACE_MSB:`FC_SPACE_LSB];
  wire       launch = fc_wr && !program_busy_flag_reg && unlock_armed_reg
                      && (wr_nib == `LAUNCH_SECOND)
                      && (wr_space != `SPACE_RESERVED);
  wire       latch_wr = i_xdata_wr && latch_map_select_reg
                        && !program_busy_flag_reg;
  wire [7:0] rd_data;
  wire       rd_loaded;

  assign o_flash_control = {launch_code_nibble_reg, latch_map_select_reg,
                            flash_space_select_reg, program_busy_flag_reg};
  assign o_xdata_to_latches     = latch_map_select_reg;
  assign o_flash_space_select   = flash_space_select_reg;
  assign o_flash_read_space_sel = (flash_space_select_reg != `SPACE_USER);
  // Fetch wait follows the busy flag; no wait state is added while programming is not busy.
  assign o_fetch_wait = program_busy_flag_reg;
  assign o_cpu_idle   = program_busy_flag_reg;

  // --------------------------------------------------------------------
  // Flash control register.
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      launch_code_nibble_reg <= 4'h0;
      latch_map_select_reg   <= 1'b0;
      flash_space_select_reg <= 2'b00;
      unlock_armed_reg       <= 1'b0;
    end
    else if (fc_wr)
    begin
      latch_map_select_reg <= i_sfr_wdata[`FC_LATCH_MAP_BIT];
      if (!program_busy_flag_reg)
      begin
        launch_code_nibble_reg <= wr_nib;
        flash_space_select_reg <= wr_space;
        // Any other second write disarms; 5 arms afresh.
        unlock_armed_reg <= (wr_nib == `LAUNCH_FIRST);
      end
    end
  end

  // --------------------------------------------------------------------
  // Page address capture: last loaded page selects the target.
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      page_reg <= 8'h00;
    end
    else if (latch_wr)
    begin
      page_reg <= i_xdata_addr[14:7];
    end
  end

  column_latch_mem u_latches
  (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .i_wr_en        (latch_wr),
    .i_wr_addr      (i_xdata_addr[6:0]),
    .i_wr_data      (i_xdata_wdata),
    .i_clear_loaded (state_reg == ST_WAIT && time_reg == PROG_LAST),
    .i_rd_addr      (scan_reg[6:0]),
    .o_rd_data      (rd_data),
    .o_rd_loaded    (rd_loaded)
  );

  // --------------------------------------------------------------------
  // Sequencer: scan loaded bytes, erase then write each, then hold busy.
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg             <= ST_IDLE;
      program_busy_flag_reg <= 1'b0;
      time_reg              <= 24'h0;
      scan_reg              <= 8'h00;
      scan_valid_reg        <= 1'b0;
      scan_byte_reg         <= 7'h00;
      o_array_erase         <= 1'b0;
      o_array_write         <= 1'b0;
      o_array_space         <= 2'b00;
      o_array_page          <= 8'h00;
      o_array_byte          <= 7'h00;
      o_array_data          <= 8'h00;
    end
    else
    begin
      o_array_erase <= 1'b0;
      o_array_write <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (launch)
          begin
            state_reg             <= ST_SCAN;
            program_busy_flag_reg <= 1'b1;
            o_array_space         <= wr_space;
            o_array_page          <= page_reg;
            time_reg              <= 24'h0;
            scan_reg              <= 8'h00;
            scan_valid_reg        <= 1'b0;
          end
        end
        ST_SCAN:
        begin
          time_reg       <= time_reg + 24'h1;
          scan_reg       <= scan_reg + 8'h1;
          scan_valid_reg <= 1'b1;
          scan_byte_reg  <= scan_reg[6:0];
          if (scan_valid_reg && rd_loaded)
          begin
            // Erase and write strobe together; the array erases first.
            o_array_erase <= 1'b1;
            o_array_write <= 1'b1;
            o_array_byte  <= scan_byte_reg;
            o_array_data  <= rd_data;
          end
          if (scan_reg == `PAGE_BYTES)
          begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          time_reg <= time_reg + 24'h1;
          if (time_reg == PROG_LAST)
          begin
            state_reg             <= ST_IDLE;
            program_busy_flag_reg <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Security byte: parallel programmer only while lock bits are 111, or a security-space launch.
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hsb_reg     <= `HSB_RESET;
      ea_sync_reg <= 2'b11;
    end
    else
    begin
      ea_sync_reg <= {ea_sync_reg[0], i_external_access_pin};
      if (i_par_hsb_wr && o_lock_level_m1 < 3'd1)
      begin
        hsb_reg <= i_par_hsb_wdata;
      end
      else if (o_array_write && o_array_space == `SPACE_SECURITY
               && o_array_byte == 7'h00)
      begin
        // Software updates only the upper nibble.
        hsb_reg[7:4] <= o_array_data[7:4];
      end
    end
  end

  assign o_hardware_security_byte = {hsb_reg[7:4], 1'b0, hsb_reg[2:0]};
  assign o_clock_ratio_select = hsb_reg[`HSB_CLOCK_RATIO_BIT];
  assign o_boot_address = hsb_reg[`HSB_BOOT_SELECT_BIT] ?
                          `BOOT_ADDR_USER : `BOOT_ADDR_LOADER;
  assign o_osc_range_field = hsb_reg[`HSB_OSC_MSB:`HSB_OSC_LSB];
  assign o_osc_range_illegal = (o_osc_range_field == 2'b00);
  assign o_memory_lock_bits = hsb_reg[`HSB_LOCK_MSB:`HSB_LOCK_LSB];
  // Level minus one: 0 none, 1 level 2, 2 level 3, 3 level 4.
  assign o_lock_level_m1 = !o_memory_lock_bits[2] ? 3'd3 :
                           !o_memory_lock_bits[1] ? 3'd2 :
                           !o_memory_lock_bits[0] ? 3'd1 : 3'd0;
  assign o_block_ext_movc        = (o_lock_level_m1 >= 3'd1);
  assign o_block_parallel_prog   = (o_lock_level_m1 >= 3'd1);
  assign o_block_parallel_verify = (o_lock_level_m1 >= 3'd2);
  assign o_block_ext_exec        = (o_lock_level_m1 >= 3'd3);
  assign o_internal_code_enable  = ea_sync_reg[1];

endmodule // flash_program_control

`default_nettype wire

// ---- core/flash_program_control_consts.vh ----
`ifndef FLASH_PROGRAM_CONTROL_CONSTS_VH
`define FLASH_PROGRAM_CONTROL_CONSTS_VH

// Special function register address of the flash control register.
`define FLASH_CONTROL_ADDR     8'hd1
`define FLASH_CONTROL_RESET    8'h00

// Flash control field positions.
`define FC_LAUNCH_MSB          7
`define FC_LAUNCH_LSB          4
`define FC_LATCH_MAP_BIT       3
`define FC_SPACE_MSB           2
`define FC_SPACE_LSB           1
`define FC_BUSY_BIT            0

// Launch codes in the upper nibble.
`define LAUNCH_FIRST           4'h5
`define LAUNCH_SECOND          4'ha

// Flash space select encodings.
`define SPACE_USER             2'b00
`define SPACE_EXTRA_ROW        2'b01
`define SPACE_SECURITY         2'b10
`define SPACE_RESERVED         2'b11

// Security byte field positions.
`define HSB_CLOCK_RATIO_BIT    7
`define HSB_BOOT_SELECT_BIT    6
`define HSB_OSC_MSB            5
`define HSB_OSC_LSB            4
`define HSB_LOCK_MSB           2
`define HSB_LOCK_LSB           0
`define HSB_RESET              8'hb8

// Array geometry.
`define PAGE_COUNT             256
`define PAGE_BYTES             128
`define PAGE_ADDR_W            8
`define BYTE_ADDR_W            7
`define EXTRA_ROW_BASE         16'hff80
`define BOOT_ADDR_USER         16'h0000
`define BOOT_ADDR_LOADER       16'hf400

// Programming time in microseconds and clock rate in MHz.
`define PROG_TIME_US           10000
`define CORE_CLK_MHZ           125
`define PROG_CYCLES            (`PROG_TIME_US * `CORE_CLK_MHZ)

`endif

// ---- core/column_latch_mem.v ----
`default_nettype none

// ----------------------------------------------------------------------
// Page buffer of column latches with a loaded flag per byte.
// ----------------------------------------------------------------------
module column_latch_mem
(
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_wr_en,
  input  wire [6:0] i_wr_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_clear_loaded,
  input  wire [6:0] i_rd_addr,
  output reg  [7:0] o_rd_data,
  output reg        o_rd_loaded
);

  reg [7:0]   latch_mem [0:127];
  reg [127:0] loaded_reg;

  always @(posedge i_core_clk)
  begin
    if (i_wr_en)
    begin
      latch_mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= latch_mem[i_rd_addr];
  end

  // A write in the clearing cycle still marks its byte as loaded.
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      loaded_reg  <= 128'h0;
      o_rd_loaded <= 1'b0;
    end
    else
    begin
      if (i_clear_loaded)
      begin
        loaded_reg <= 128'h0;
      end
      if (i_wr_en)
      begin
        loaded_reg[i_wr_addr] <= 1'b1;
      end
      o_rd_loaded <= loaded_reg[i_rd_addr];
    end
  end

endmodule // column_latch_mem

`default_nettype wire

// ---- verif/flash_program_control_props.sv ----
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the flash sequencer.
// ----------------------------------------------------------------------
module flash_program_control_props
#(
  parameter PROG_CYCLES = 300
)
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_sfr_wr,
  input wire logic [7:0]  i_sfr_addr,
  input wire logic [7:0]  i_sfr_wdata,
  input wire logic [7:0]  o_flash_control,
  input wire logic        o_xdata_to_latches,
  input wire logic        o_cpu_idle,
  input wire logic        o_fetch_wait,
  input wire logic        i_external_access_pin,
  input wire logic        o_internal_code_enable,
  input wire logic        o_array_write,
  input wire logic        o_array_erase,
  input wire logic [7:0]  o_hardware_security_byte,
  input wire logic [15:0] o_boot_address,
  input wire logic        o_osc_range_illegal,
  input wire logic        o_block_ext_exec,
  input wire logic        o_block_parallel_prog
);
  // The armed state mirrors the unlock sequence so a launch can be judged.
  logic        armed_reg;
  int unsigned bcnt_reg;
  wire         fw   = i_sfr_wr && i_sfr_addr == 8'hd1;
  wire         busy = o_flash_control[0];
  wire  [7:0]  hardware_security_byte  = o_hardware_security_byte;
  wire         go   = fw && armed_reg && !busy && i_sfr_wdata[7:4] == 4'ha;
  wire         pin  = i_external_access_pin;
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      armed_reg <= 1'b0;
      bcnt_reg  <= 0;
    end
    else
    begin
      if (fw && !busy)
        armed_reg <= i_sfr_wdata[7:4] == 4'h5;
      bcnt_reg <= busy ? bcnt_reg + 1 : 0;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  launch_sets_busy_a: assert property (go && i_sfr_wdata[2:1] != 2'b11
    |=> busy && o_cpu_idle) else $error("launch did not set busy");
  busy_cause_a: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without unlock");
  reserved_space_a: assert property (go && i_sfr_wdata[2:1] == 2'b11
    |=> !busy) else $error("reserved space launched");
  busy_short_a: assert property ($fell(busy)
    |-> bcnt_reg >= PROG_CYCLES - 2) else $error("busy ended early");
  busy_long_a: assert property (bcnt_reg <= PROG_CYCLES + 4)
    else $error("busy never cleared");
  reset_value_a: assert property ($rose(i_rst_n)
    |-> o_flash_control == 8'h00) else $error("control not zero after reset");
  busy_frozen_a: assert property (fw && busy
    |=> $stable({o_flash_control[7:4], o_flash_control[2:1]}))
    else $error("fields changed while busy");
  latch_map_a: assert property (fw && !busy && !go
    |=> o_xdata_to_latches == $past(i_sfr_wdata[3])) else $error("latch map");
  idle_level_a: assert property (o_cpu_idle == busy
    && o_fetch_wait == busy) else $error("idle differs from busy");
  erase_first_a: assert property (o_array_write
    |-> o_array_erase && busy) else $error("write without erase");
  hsb_decode_a: assert property (o_boot_address == (hardware_security_byte[6] ? 16'h0000
    : 16'hf400) && o_osc_range_illegal == (hardware_security_byte[5:4] == 2'b00) && !hardware_security_byte[3])
    else $error("security decode wrong");
  lock_level_a: assert property (o_block_ext_exec == !hardware_security_byte[2]
    && o_block_parallel_prog == (hardware_security_byte[2:0] != 3'b111)) else $error("lock");
  pin_sync_a: assert property (pin == $past(pin)
    && pin == $past(pin, 2) |-> o_internal_code_enable == pin)
    else $error("code enable wrong");
endmodule // flash_program_control_props

bind flash_program_control flash_program_control_props
#(.PROG_CYCLES(PROG_CYCLES)) u_props (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wdata(i_sfr_wdata), .o_flash_control(o_flash_control),
  .o_xdata_to_latches(o_xdata_to_latches), .o_cpu_idle(o_cpu_idle),
  .o_fetch_wait(o_fetch_wait), .i_external_access_pin(i_external_access_pin),
  .o_internal_code_enable(o_internal_code_enable),
  .o_array_write(o_array_write), .o_array_erase(o_array_erase),
  .o_hardware_security_byte(o_hardware_security_byte),
  .o_boot_address(o_boot_address), .o_osc_range_illegal(o_osc_range_illegal),
  .o_block_ext_exec(o_block_ext_exec),
  .o_block_parallel_prog(o_block_parallel_prog));
`default_nettype wire

// ---- verif/tb_flash_program_control.sv ----
`default_nettype none
module tb_flash_program_control;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // Bench signals. A short programming time keeps the run brief.
  // --------------------------------------------------------------------
  localparam int P = 300;
  logic core_clk, rst_n, sfr_wr, xd_wr, pin, par_wr;
  logic [7:0] sfr_addr, sfr_wd, xd_wd, par_wd;
  logic [15:0] xd_addr;
  logic [24:0] last_pulse;
  wire [7:0] fc, hardware_security_byte, a_page, a_data;
  wire [6:0] a_byte;
  wire [1:0] a_space, sp_sel, osc;
  wire [15:0] boot;
  wire [2:0] lk, lvl;
  wire lat, rsel, fwait, idle, aer, awr, cr, oscill, ice, bmv, bpp, bpv, bex;
  int n_errors = 0, comparisons = 0, pulses = 0, n, i;
  logic [7:0] hv [2] = '{8'h7f, 8'h4f};
  // The reserved bit 3 of the security byte always reads as zero.
  logic [7:0] he [2] = '{8'h70, 8'h40};
  flash_program_control #(.PROG_CYCLES(P)) uut (.i_core_clk(core_clk),
    .i_rst_n(rst_n), .i_sfr_wr(sfr_wr), .i_sfr_addr(sfr_addr),
    .i_sfr_wdata(sfr_wd), .o_flash_control(fc), .i_xdata_wr(xd_wr),
    .i_xdata_addr(xd_addr), .i_xdata_wdata(xd_wd), .o_xdata_to_latches(lat),
    .o_flash_read_space_sel(rsel), .o_flash_space_select(sp_sel),
    .o_fetch_wait(fwait), .o_cpu_idle(idle), .i_external_access_pin(pin),
    .i_par_hsb_wr(par_wr), .i_par_hsb_wdata(par_wd), .o_array_erase(aer),
    .o_array_write(awr), .o_array_space(a_space), .o_array_page(a_page),
    .o_array_byte(a_byte), .o_array_data(a_data),
    .o_hardware_security_byte(hardware_security_byte), .o_clock_ratio_select(cr),
    .o_boot_address(boot), .o_osc_range_field(osc),
    .o_osc_range_illegal(oscill), .o_memory_lock_bits(lk),
    .o_lock_level_m1(lvl), .o_internal_code_enable(ice),
    .o_block_ext_movc(bmv), .o_block_parallel_prog(bpp),
    .o_block_parallel_verify(bpv), .o_block_ext_exec(bex));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (awr === 1'b1 && aer === 1'b1)
    begin
      pulses++;
      last_pulse <= {a_space, a_page, a_byte, a_data};
    end
  // --------------------------------------------------------------------
  // Access tasks and comparison.
  // --------------------------------------------------------------------
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wd <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic xd(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    xd_wr <= 1'b1;
    xd_addr <= a;
    xd_wd <= d;
    @(posedge core_clk);
    xd_wr <= 1'b0;
  endtask
  task automatic launch(input logic [7:0] lo);
    sfr(8'hd1, 8'h50 | lo);
    sfr(8'hd1, 8'ha0 | lo);
  endtask
  task automatic wait_idle();
    n = 0;
    while (fc[0] !== 1'b0 && n < 2000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("watchdog expired");
    end_of_test;
  end
  initial
  begin
    {sfr_wr, xd_wr, par_wr, sfr_wd, xd_wd, par_wd, xd_addr} = 0;
    pin = 1'b1;
    sfr_addr = 8'hd1;
    rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(fc, 8'h00);
    chk({boot, cr, osc, oscill}, {16'hf400, 1'b1, 2'b11, 1'b0});
    chk({bmv, bpp, bpv, bex, lk, lvl}, {4'hf, 3'b000, 3'd3});
    done("reset");
    sfr(8'hd1, 8'h08);
    chk(lat, 1'b1);
    sfr(8'hd0, 8'h00);
    chk(fc, 8'h08);
    sfr(8'hd1, 8'h02);
    chk({lat, sp_sel, rsel}, {1'b0, 2'b01, 1'b1});
    done("mapping");
    sfr(8'hd1, 8'h50);
    sfr(8'hd1, 8'h08);
    sfr(8'hd1, 8'ha0);
    chk(fc[0], 1'b0);
    launch(8'h06);
    chk(fc[0], 1'b0);
    done("refused launch");
    sfr(8'hd1, 8'h08);
    xd(16'h0283, 8'h3c);
    xd(16'h0290, 8'hc5);
    launch(8'h00);
    chk({fc[0], idle, fwait}, 3'b111);
    sfr(8'hd1, 8'h52);
    chk({fc[7:4], fc[2:0]}, {4'ha, 3'b001});
    wait_idle();
    chk(n >= P - 3 && n <= P + 3, 1'b1);
    chk(pulses, 2);
    chk(last_pulse, {2'b00, 8'h05, 7'h10, 8'hc5});
    done("user page");
    sfr(8'hd1, 8'h08);
    xd(16'hff85, 8'h11);
    launch(8'h02);
    wait_idle();
    chk(pulses, 3);
    chk({last_pulse[24:23], last_pulse[7:0]}, {2'b01, 8'h11});
    done("extra row");
    @(posedge core_clk);
    par_wr <= 1'b1;
    par_wd <= 8'hff;
    @(posedge core_clk);
    par_wr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(hardware_security_byte, 8'hb0);
    for (i = 0; i < 2; i++)
    begin
      sfr(8'hd1, 8'h0c);
      xd(16'h0000, hv[i]);
      launch(8'h04);
      wait_idle();
      chk(hardware_security_byte, he[i]);
    end
    chk({boot, cr, oscill}, {16'h0000, 1'b0, 1'b1});
    done("security byte");
    @(posedge core_clk);
    pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk(ice, 1'b0);
    done("external access");
    end_of_test;
  end
endmodule // tb_flash_program_control
`default_nettype wire
